// File: hw/power_up_reset_sequencer.sv
// Purpose: master reset release, nvm load ordering, reset fan-out per unit
// Assumes: nvm reader, link layer and config space are outside this block
// Notes: reset outputs are active high and registered
// Summary of operation
// [RULE1] hold master reset until supplies good, release 35 ms after 156 MHz clock stable
// [RULE2] start nvm read on rising edge of power-on reset or power-good
// [RULE3] after init/analog and pll lock, load core/mac if manageability or wake enabled
// [RULE4] host-link reset release re-reads core, mac, link analog, general, config space
// [RULE5] start link training within 20 ms of host-link reset release
// [RULE6] able to answer first config request within 1 s of host-link release
// [RULE7] host waits 100 ms after host-link release before first config access
// [RULE8] host gives valid reference clock 100 us before host-link release
// [RULE9] host holds host-link reset 100 ms after rails stable
// [RULE10] memory access enable write moves uninitialized active to active state
// [RULE11] power-on reset is level sensitive and holds every register
// [RULE12] most units reset on host-link rise; host io unit held while asserted
// [RULE13] link reset message or drop to polling/detect gives in-band reset
// [RULE14] d3hot to d0 change resets only that function
// [RULE15] software reset per function, re-reads its nvm fields, config space kept
// [RULE16] driver runs bus-master disable before software or link reset
// [RULE17] every link reset also performs full software reset of the function
// [RULE18] firmware reset from bit, firmware or watchdog clears manageability unit
// [RULE19] por loads global, host-link loads link, per-function resets load function
// [RULE20] por/host-link/in-band clear link fsm, data path, ro cfg, straps; rw adds d3hot
// [RULE21] all but firmware reset clear data path; pins/flash only on por
// [RULE22] mac always on por and link reset; others only if mng off, low power, no wake
// [RULE23] wake context reset by por/host-link only without aux power; others por only
// [RULE24] each async reset source synchronised, async assert, sync release
module power_up_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned PPG_COUNT = PPG_CYCLES,
    parameter int unsigned TRAIN_COUNT = TRAIN_CYCLES,
    parameter int unsigned CFG_RESP_COUNT = CFG_RESP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic supplies_good,
    input wire logic external_power_good,
    input wire logic ref_clock_156m_stable,
    input wire logic pll_stable,
    input wire logic host_link_reset_n,
    input wire logic link_reset_msg,
    input wire logic link_down_detect,
    input wire logic [NUM_FUNCS-1:0] d3hot_to_d0,
    input wire logic [NUM_FUNCS-1:0] sw_reset_bit,
    input wire logic [NUM_FUNCS-1:0] mac_link_reset_bit,
    input wire logic firmware_reset_bit,
    input wire logic firmware_reset_req,
    input wire logic watchdog_expired,
    input wire logic mem_access_enable_write,
    input wire logic mng_enabled,
    input wire logic wake_enabled,
    input wire logic host_low_power,
    input wire logic aux_power_present,
    input wire logic nvm_busy,
    output logic master_reset,
    output nvm_sections_t nvm_load,
    output logic [NUM_FUNCS-1:0] nvm_func_load,
    output logic start_link_training,
    output logic cfg_response_ready,
    output logic device_active,
    output global_resets_t global_resets,
    output func_resets_t [NUM_FUNCS-1:0] func_resets
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    initial begin
        if (PPG_COUNT < 1 || TRAIN_COUNT < 1 || CFG_RESP_COUNT < 1) begin
            $error("power_up_reset_sequencer: counts must be at least 1");
        end
    end

    // ------------------------------------------------------------
    // reset synchronisers
    // ------------------------------------------------------------
    logic por_hold;
    logic pgood_hold;
    logic host_hold;

    reset_sync u_por_sync (.sys_clk(sys_clk), .arst_n(reset_n), .rst_hold(por_hold)); // RULE24
    reset_sync u_pg_sync (.sys_clk(sys_clk), .arst_n(external_power_good & reset_n),
        .rst_hold(pgood_hold)); // RULE24
    reset_sync u_host_sync (.sys_clk(sys_clk), .arst_n(host_link_reset_n & reset_n),
        .rst_hold(host_hold)); // RULE24

    logic host_hold_d;
    logic pgood_hold_d;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_hold_d <= 1'b1;
            pgood_hold_d <= 1'b1;
        end else begin
            host_hold_d <= host_hold;
            pgood_hold_d <= pgood_hold;
        end
    end

    logic host_release;
    logic pgood_rise;
    logic inband;
    logic firmware_reset;
    assign host_release = host_hold_d & ~host_hold; // RULE12
    assign pgood_rise = pgood_hold_d & ~pgood_hold; // RULE2
    assign inband = link_reset_msg | link_down_detect; // RULE13
    assign firmware_reset = firmware_reset_bit | firmware_reset_req | watchdog_expired; // RULE18

    // ------------------------------------------------------------
    // master reset release
    // ------------------------------------------------------------
    seq_state_t state;
    logic ppg_done;
    logic ppg_start;
    logic por_release;
    assign ppg_start = (state == SEQ_WAIT_POWER) && supplies_good && ref_clock_156m_stable;

    delay_timer #(.COUNT(PPG_COUNT)) u_ppg (
        .sys_clk(sys_clk), .reset_n(reset_n), .clear(por_hold | ~supplies_good),
        .start(ppg_start), .done(ppg_done)); // RULE1

    assign por_release = (state == SEQ_WAIT_DELAY) && ppg_done && supplies_good;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SEQ_WAIT_POWER; // RULE11
        end else if (!supplies_good) begin
            state <= SEQ_WAIT_POWER; // RULE1
        end else begin
            unique case (state)
                SEQ_WAIT_POWER: if (ppg_start) state <= SEQ_WAIT_DELAY;
                SEQ_WAIT_DELAY: if (por_release) state <= SEQ_LOAD_INIT; // RULE1
                SEQ_LOAD_INIT: begin
                    if (!nvm_busy && pll_stable) begin
                        state <= (mng_enabled | wake_enabled) ? SEQ_LOAD_CORE : SEQ_IDLE;
                    end // RULE3
                end
                SEQ_LOAD_CORE: if (!nvm_busy) state <= SEQ_IDLE; // RULE3
                SEQ_IDLE: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            master_reset <= 1'b1; // RULE11
        end else begin
            master_reset <= (state == SEQ_WAIT_POWER) || (state == SEQ_WAIT_DELAY); // RULE1
        end
    end

    // ------------------------------------------------------------
    // nvm load requests (one-cycle pulses)
    // ------------------------------------------------------------
    logic por_load;
    logic core_load;
    assign por_load = por_release | (pgood_rise && state == SEQ_IDLE); // RULE2
    assign core_load = (state == SEQ_LOAD_INIT) && !nvm_busy && pll_stable
        && (mng_enabled | wake_enabled); // RULE3

    logic [NUM_FUNCS-1:0] func_event;
    assign func_event = d3hot_to_d0 | sw_reset_bit | mac_link_reset_bit
        | {NUM_FUNCS{inband}}; // RULE19

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            nvm_load <= '0;
            nvm_func_load <= '0;
        end else begin
            nvm_load.init_analog <= por_load; // RULE19
            nvm_load.core_mac <= core_load | host_release; // RULE4
            nvm_load.link_analog <= host_release; // RULE4
            nvm_load.link_general <= host_release; // RULE4
            nvm_load.config_space <= host_release; // RULE4
            nvm_load.per_function <= |func_event; // RULE15 RULE17
            nvm_func_load <= func_event; // RULE19
        end
    end

    // ------------------------------------------------------------
    // link timing after host-link release
    // ------------------------------------------------------------
    logic train_done;
    logic resp_done;
    delay_timer #(.COUNT(TRAIN_COUNT)) u_train (
        .sys_clk(sys_clk), .reset_n(reset_n), .clear(host_hold | inband),
        .start(host_release), .done(train_done)); // RULE5
    delay_timer #(.COUNT(CFG_RESP_COUNT)) u_resp (
        .sys_clk(sys_clk), .reset_n(reset_n), .clear(host_hold),
        .start(host_release), .done(resp_done)); // RULE6

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            start_link_training <= 1'b0;
            cfg_response_ready <= 1'b0;
        end else begin
            start_link_training <= train_done & ~host_hold; // RULE5
            cfg_response_ready <= resp_done & ~host_hold & ~master_reset; // RULE6
        end
    end

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    pm_state_t pm;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pm <= PM_UNINIT_ACTIVE;
        end else if (host_hold || inband) begin
            pm <= PM_UNINIT_ACTIVE;
        end else if (pm == PM_UNINIT_ACTIVE && mem_access_enable_write) begin
            pm <= PM_ACTIVE; // RULE10
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            device_active <= 1'b0;
        end else begin
            device_active <= (pm == PM_ACTIVE) || (pm == PM_UNINIT_ACTIVE
                && mem_access_enable_write && !host_hold && !inband); // RULE10
        end
    end

    // ------------------------------------------------------------
    // reset fan-out
    // ------------------------------------------------------------
    logic por_any;
    logic link_grp;
    logic mac_gate;
    assign por_any = por_hold | master_reset | pgood_hold; // RULE11
    assign link_grp = por_any | host_release | inband; // RULE12 RULE20
    assign mac_gate = ~mng_enabled & host_low_power & ~wake_enabled; // RULE22

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            global_resets <= '1;
        end else begin
            global_resets.link_training_fsm <= link_grp; // RULE20
            global_resets.link_data_path <= link_grp; // RULE20
            global_resets.cfg_ro <= link_grp; // RULE20
            global_resets.strap_sample <= link_grp; // RULE20
            global_resets.host_io_unit <= por_any | host_hold; // RULE12
            global_resets.soft_defined_pins <= por_any; // RULE21
            global_resets.flash_access_reg <= por_any; // RULE21
            global_resets.wake_context <= (por_any | host_release)
                & ~aux_power_present; // RULE23
            global_resets.wake_mng_regs <= por_any; // RULE23
            global_resets.mng_unit <= por_any | firmware_reset; // RULE18
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            func_resets <= '1;
        end else begin
            for (int f = 0; f < NUM_FUNCS; f++) begin
                func_resets[f].cfg_rw <= link_grp | d3hot_to_d0[f]; // RULE14 RULE20
                func_resets[f].data_path <= link_grp | d3hot_to_d0[f] | sw_reset_bit[f]
                    | mac_link_reset_bit[f]; // RULE15 RULE17 RULE21
                func_resets[f].mac_pcs_an <= por_any | mac_link_reset_bit[f]
                    | (mac_gate & (host_release | inband | d3hot_to_d0[f]
                    | sw_reset_bit[f])); // RULE22
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    master_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !supplies_good |=> master_reset) else $error("master reset released without supplies"); // RULE1
    release_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $fell(master_reset) |-> $past(ppg_done)) else $error("master reset released early"); // RULE1
    nvm_por_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        por_release |=> nvm_load.init_analog) else $error("nvm load missed at release"); // RULE2
    link_reload_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        host_release |=> nvm_load.config_space && nvm_load.link_analog
        && nvm_load.core_mac) else $error("link sections not reloaded"); // RULE4
    core_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        core_load |-> (mng_enabled || wake_enabled)) else $error("core load without enable"); // RULE3
    hostio_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        host_hold |=> global_resets.host_io_unit) else $error("host io unit released"); // RULE12
    active_move_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (pm == PM_UNINIT_ACTIVE && mem_access_enable_write && !host_hold && !inband)
        |=> pm == PM_ACTIVE) else $error("no move to active"); // RULE10
    mng_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        watchdog_expired |=> global_resets.mng_unit) else $error("watchdog missed mng reset"); // RULE18
    link_mac_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mac_link_reset_bit[0] |=> func_resets[0].mac_pcs_an && func_resets[0].data_path
        && nvm_func_load[0]) else $error("link reset incomplete"); // RULE17
    wake_aux_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        aux_power_present |=> !global_resets.wake_context) else $error("wake context lost"); // RULE23
    fw_only_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (firmware_reset && !por_any && !host_release && !inband && !d3hot_to_d0[0]
        && !sw_reset_bit[0] && !mac_link_reset_bit[0]) |=> !func_resets[0].data_path)
        else $error("firmware reset touched data path"); // RULE21

    boot_done_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $fell(master_reset));
    link_train_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(start_link_training));
    active_c: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(device_active));
endmodule // power_up_reset_sequencer

// File: include/reset_seq_pkg.sv
// Purpose: shared constants and types for the power-up reset sequencer
// Assumes: 20 MHz core clock
// Notes: times kept in their own units, cycle counts derived from them
package reset_seq_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned PPG_MS = 35;
    localparam int unsigned TRAIN_MS = 20;
    localparam int unsigned CFG_RESP_MS = 1000;
    localparam int unsigned PPG_CYCLES = CLK_HZ / 1000 * PPG_MS;
    localparam int unsigned TRAIN_CYCLES = CLK_HZ / 1000 * TRAIN_MS;
    localparam int unsigned CFG_RESP_CYCLES = CLK_HZ / 1000 * CFG_RESP_MS;
    localparam int unsigned NUM_FUNCS = 2;

    // nvm section select, one bit per section
    typedef struct packed {
        logic init_analog;
        logic core_mac;
        logic link_analog;
        logic link_general;
        logic config_space;
        logic per_function;
    } nvm_sections_t;

    // per-unit reset outputs (high = unit held in reset)
    typedef struct packed {
        logic link_training_fsm;
        logic link_data_path;
        logic cfg_ro;
        logic strap_sample;
        logic host_io_unit;
        logic soft_defined_pins;
        logic flash_access_reg;
        logic wake_context;
        logic wake_mng_regs;
        logic mng_unit;
    } global_resets_t;

    typedef struct packed {
        logic cfg_rw;
        logic data_path;
        logic mac_pcs_an;
    } func_resets_t;

    typedef enum logic [2:0] {
        SEQ_WAIT_POWER,
        SEQ_WAIT_DELAY,
        SEQ_LOAD_INIT,
        SEQ_LOAD_CORE,
        SEQ_IDLE
    } seq_state_t;

    typedef enum logic [1:0] {
        PM_UNINIT_ACTIVE,
        PM_ACTIVE,
        PM_D3HOT
    } pm_state_t;
endpackage

// File: hw/reset_sync.sv
// Purpose: async-assert, sync-deassert reset synchroniser
// Assumes: output high means reset held
// Notes: first stage is read only by the second stage
module reset_sync (
    input wire logic sys_clk,
    input wire logic arst_n,
    output logic rst_hold
);
    logic stage1;
    logic stage2;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            stage2 <= stage1;
        end
    end

    assign rst_hold = ~stage2;
endmodule // reset_sync

// File: hw/delay_timer.sv
// Purpose: one-shot cycle counter, done after COUNT cycles from start
// Assumes: start is a one-cycle pulse, restart allowed
// Notes: done is a level until the next start or clear
module delay_timer #(
    parameter int unsigned COUNT = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic start,
    output logic done
);
    localparam int unsigned W = $clog2(COUNT + 1);
    logic [W-1:0] cnt;
    logic running;

    initial begin
        if (COUNT < 1) $error("delay_timer: COUNT must be at least 1");
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else if (clear) begin
            cnt <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            cnt <= W'(1);
            running <= 1'b1;
            done <= 1'b0;
        end else if (running) begin
            if (cnt == W'(COUNT)) begin
                running <= 1'b0;
                done <= 1'b1;
            end else begin
                cnt <= cnt + W'(1);
            end
        end
    end
endmodule // delay_timer

// File: testbench/host_platform_model.sv
// Purpose: host side model: rails, reference clock, host-link reset
// Assumes: scaled counts
// Notes: link_reset_req re-asserts host-link reset
module host_platform_model #(
    parameter int unsigned RAIL_HOLD = 40,
    parameter int unsigned CFG_WAIT = 60
) (
    input wire logic sys_clk,
    input wire logic power_on,
    input wire logic link_reset_req,
    output logic supplies_good,
    output logic ref_clock_156m_stable,
    output logic pll_stable,
    output logic host_link_reset_n,
    output logic cfg_access_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        supplies_good = 1'b0;
        ref_clock_156m_stable = 1'b0;
        pll_stable = 1'b0;
        host_link_reset_n = 1'b0;
        cfg_access_ok = 1'b0;
        wait (power_on);
        @(posedge sys_clk);
        supplies_good <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ref_clock_156m_stable <= 1'b1;
        pll_stable <= 1'b1;
        forever begin
            repeat (RAIL_HOLD) @(posedge sys_clk);
            host_link_reset_n <= 1'b1;
            repeat (CFG_WAIT) @(posedge sys_clk);
            cfg_access_ok <= 1'b1;
            wait (link_reset_req);
            @(posedge sys_clk);
            host_link_reset_n <= 1'b0;
            cfg_access_ok <= 1'b0;
        end
    end
endmodule // host_platform_model

// File: testbench/power_up_reset_sequencer_tb_top.sv
// Purpose: bench for the reset sequencer
// Assumes: scaled counts
// Notes: nvm load pulses checked against a queue of notes
module power_up_reset_sequencer_tb_top import reset_seq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PPG = 10, TRN = 20, CFR = 50;
    typedef struct packed {
        nvm_sections_t sec;
        logic [NUM_FUNCS-1:0] fl;
    } load_note_t;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic link_reset_msg = 1'b0;
    logic link_down_detect = 1'b0;
    logic [NUM_FUNCS-1:0] d3hot_to_d0 = '0;
    logic [NUM_FUNCS-1:0] sw_reset_bit = '0;
    logic [NUM_FUNCS-1:0] mac_link_reset_bit = '0;
    logic [2:0] fw_src = '0;
    logic mem_access_enable_write = 1'b0;
    logic mng_enabled = 1'b0;
    logic wake_enabled = 1'b0;
    logic host_low_power = 1'b0;
    logic aux_power_present = 1'b0;
    logic power_on = 1'b0, nvm_busy = 1'b0, external_power_good = 1'b1;
    logic link_reset_req = 1'b0;
    logic supplies_good, ref_clock_156m_stable, pll_stable, host_link_reset_n, cfg_access_ok;
    logic master_reset, start_link_training, cfg_response_ready, device_active, mac_c;
    nvm_sections_t nvm_load;
    logic [NUM_FUNCS-1:0] nvm_func_load;
    global_resets_t global_resets, glob_acc;
    func_resets_t [NUM_FUNCS-1:0] func_resets, func_acc;
    load_note_t notes[$];
    logic [31:0] exp_v;
    int unsigned n_fail = 0;
    int unsigned checked = 0;

    always #25 sys_clk = ~sys_clk;
    assign mac_c = !mng_enabled && host_low_power && !wake_enabled;

    power_up_reset_sequencer #(.PPG_COUNT(PPG), .TRAIN_COUNT(TRN), .CFG_RESP_COUNT(CFR)) i_dut (
        .sys_clk, .reset_n, .supplies_good, .external_power_good, .ref_clock_156m_stable,
        .pll_stable, .host_link_reset_n, .link_reset_msg, .link_down_detect, .d3hot_to_d0,
        .sw_reset_bit, .mac_link_reset_bit, .firmware_reset_bit(fw_src[0]),
        .firmware_reset_req(fw_src[1]), .watchdog_expired(fw_src[2]),
        .mem_access_enable_write, .mng_enabled, .wake_enabled, .host_low_power,
        .aux_power_present, .nvm_busy, .master_reset, .nvm_load, .nvm_func_load,
        .start_link_training, .cfg_response_ready, .device_active, .global_resets, .func_resets
    );
    host_platform_model i_host (
        .sys_clk, .power_on, .link_reset_req, .supplies_good, .ref_clock_156m_stable,
        .pll_stable, .host_link_reset_n, .cfg_access_ok
    );

    // ----------------------------------------
    // compare and drive tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checked %0d failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_bits(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic probe(input int s);
        case (s)
            0: return master_reset;
            1: return start_link_training;
            2: return device_active;
            default: return host_link_reset_n;
        endcase
    endfunction

    task automatic wait_span(input string what, input int s, input logic want,
                             input int unsigned lo, input int unsigned hi);
        int unsigned n = 0;
        while (probe(s) !== want && n <= hi) begin
            @(negedge sys_clk);
            n++;
        end
        checked++;
        if (n < lo || n > hi) begin
            n_fail++;
            $display("FAIL %s expected %0d to %0d cycles seen %0d", what, lo, hi, n);
        end
    endtask

    function automatic logic [31:0] fexp(input logic [1:0] m, input logic rw, input logic mac);
        fexp = '0;
        for (int f = 0; f < NUM_FUNCS; f++) begin
            fexp[3*f +: 3] = m[f] ? {rw, 1'b1, mac} : 3'h0;
        end
    endfunction

    task automatic pick_levels(input logic [3:0] v);
        @(posedge sys_clk);
        {mng_enabled, wake_enabled, host_low_power, aux_power_present} <= v;
    endtask

    task automatic pulse(input int kind, input int f);
        @(posedge sys_clk);
        case (kind)
            0: d3hot_to_d0[f] <= 1'b1;
            1: sw_reset_bit[f] <= 1'b1;
            2: mac_link_reset_bit[f] <= 1'b1;
            3: fw_src[f] <= 1'b1;
            4: link_reset_msg <= 1'b1;
            5: link_down_detect <= 1'b1;
            default: mem_access_enable_write <= 1'b1;
        endcase
        @(posedge sys_clk);
        d3hot_to_d0 <= '0;
        sw_reset_bit <= '0;
        mac_link_reset_bit <= '0;
        fw_src <= '0;
        link_reset_msg <= 1'b0;
        link_down_detect <= 1'b0;
        mem_access_enable_write <= 1'b0;
    endtask

    task automatic capture(input int unsigned n, input bit clr);
        if (clr) begin
            glob_acc = '0;
            func_acc = '0;
        end
        repeat (n) begin
            @(negedge sys_clk);
            glob_acc |= global_resets;
            func_acc |= func_resets;
        end
    endtask

    always @(negedge sys_clk) begin : watch
        load_note_t seen;
        seen = {nvm_load, nvm_func_load};
        seen.sec.per_function = 1'b0;
        if (reset_n === 1'b1 && seen !== '0) begin
            if (notes.size() == 0) begin
                check_bits("nvm_spurious", 32'(seen), 32'h0);
            end else begin
                check_bits("nvm_load", 32'(seen), 32'(notes.pop_front()));
            end
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin : main
        void'($urandom(23309));
        pick_levels(4'($urandom()));
        repeat (8) @(posedge sys_clk);
        check_bits("held", 32'({master_reset, global_resets, func_resets}), 32'h1ffff);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check_bits("no_supply", 32'(master_reset), 32'h1);
        notes.push_back(8'h80);
        if (mng_enabled || wake_enabled) notes.push_back(8'h40);
        power_on <= 1'b1;
        wait (ref_clock_156m_stable === 1'b1);
        @(negedge sys_clk);
        wait_span("ppg", 0, 1'b0, PPG, PPG + 6);
        $display("test power_up done");
        notes.push_back(8'h78);
        wait_span("host_release", 3, 1'b1, 1, 80);
        wait_span("train", 1, 1'b1, TRN, TRN + 6);
        wait (cfg_access_ok === 1'b1);
        @(negedge sys_clk);
        check_bits("cfg_ready", 32'({cfg_response_ready, device_active}), 32'h2);
        pulse(6, 0);
        wait_span("active", 2, 1'b1, 0, 4);
        $display("test host_release done");
        for (int r = 0; r < 2; r++) begin
            pick_levels(r == 0 ? 4'h2 : 4'($urandom()));
            for (int k = 0; k < 3; k++) begin
                for (int f = 0; f < NUM_FUNCS; f++) begin
                    notes.push_back(8'(1 << f));
                    pulse(k, f);
                    capture(4, 1'b1);
                    exp_v = fexp(2'(1 << f), k == 0, k == 2 || mac_c);
                    check_bits("func", 32'(func_acc), exp_v);
                    check_bits("func_glob", 32'(glob_acc), 32'h0);
                end
            end
        end
        $display("test per_function done");
        for (int s = 0; s < 3; s++) begin
            pulse(3, s);
            capture(4, 1'b1);
            check_bits("fw_glob", 32'(glob_acc), 32'h1);
            check_bits("fw_func", 32'(func_acc), 32'h0);
        end
        for (int s = 4; s < 6; s++) begin
            notes.push_back(8'h03);
            pulse(s, 0);
            capture(4, 1'b1);
            glob_acc.host_io_unit = 1'b0;
            check_bits("inband_glob", 32'(glob_acc), 32'h3c0);
            check_bits("inband_func", 32'(func_acc), fexp(2'h3, 1'b1, mac_c));
            check_bits("inband_state", 32'(device_active), 32'h0);
        end
        $display("test fw_inband done");
        pick_levels(4'($urandom()));
        link_reset_req <= 1'b1;
        wait (host_link_reset_n === 1'b0);
        @(posedge sys_clk);
        link_reset_req <= 1'b0;
        notes.push_back(8'h78);
        capture(20, 1'b1);
        check_bits("io_held", 32'(global_resets.host_io_unit), 32'h1);
        capture(35, 1'b0);
        check_bits("link_glob", 32'(glob_acc), {29'h7c, !aux_power_present, 2'h0});
        check_bits("link_func", 32'(func_acc), fexp(2'h3, 1'b1, mac_c));
        repeat (4) @(negedge sys_clk);
        check_bits("loads_left", 32'(notes.size()), 32'h0);
        $display("test host_link_reset done");
        end_of_test();
    end

    initial begin : watchdog
        repeat (4000) @(posedge sys_clk);
        n_fail++;
        $display("FAIL watchdog expected done seen timeout");
        end_of_test();
    end
endmodule // power_up_reset_sequencer_tb_top
